/* srad_pkg.sv */
// constants, register map and state encoding for the serial register access decoder
package srad_pkg;

    // ----------------------------------------------------------------
    // frame layout
    // ----------------------------------------------------------------
    localparam int SRAD_FRAME_BITS = 16;
    localparam int SRAD_CRC_BITS = 8;
    localparam int SRAD_DATA_BITS = 12;
    localparam int SRAD_SEL_BITS = 3;
    localparam int SRAD_CNT_BITS = 5;
    localparam int SRAD_WR_POS = 15;
    localparam int SRAD_SEL_HI = 14;
    localparam int SRAD_SEL_LO = 12;
    localparam logic [SRAD_CNT_BITS-1:0] SRAD_CNT_CMD = 5'h10;
    localparam logic [SRAD_CNT_BITS-1:0] SRAD_CNT_CRC = 5'h18;
    localparam logic [SRAD_CNT_BITS-1:0] SRAD_CNT_MAX = 5'h1F;
    localparam logic [SRAD_CNT_BITS-1:0] SRAD_CNT_ZERO = 5'h00;
    localparam logic [SRAD_CNT_BITS-1:0] SRAD_CNT_ONE = 5'h01;

    // ----------------------------------------------------------------
    // register select codes and reset values
    // ----------------------------------------------------------------
    localparam logic [SRAD_SEL_BITS-1:0] SRAD_SEL_CFG1 = 3'h1;
    localparam logic [SRAD_SEL_BITS-1:0] SRAD_SEL_CFG2 = 3'h2;
    localparam logic [SRAD_SEL_BITS-1:0] SRAD_SEL_STAT = 3'h3;
    localparam logic [SRAD_SEL_BITS-1:0] SRAD_SEL_LOW = 3'h4;
    localparam logic [SRAD_SEL_BITS-1:0] SRAD_SEL_HIGH = 3'h5;
    localparam logic [SRAD_DATA_BITS-1:0] SRAD_RST_CFG1 = 12'h000;
    localparam logic [SRAD_DATA_BITS-1:0] SRAD_RST_CFG2 = 12'h000;
    localparam logic [SRAD_DATA_BITS-1:0] SRAD_RST_LOW = 12'h800;
    localparam logic [SRAD_DATA_BITS-1:0] SRAD_RST_HIGH = 12'h7FF;
    localparam logic [SRAD_DATA_BITS-1:0] SRAD_RST_STAT = 12'h000;
    localparam int SRAD_CRCW_POS = 5;

    // ----------------------------------------------------------------
    // checksum polynomial x^8 + x^2 + x + 1 without its top term
    // ----------------------------------------------------------------
    localparam logic [SRAD_CRC_BITS-1:0] SRAD_CRC_POLY = 8'h07;
    localparam logic [SRAD_CRC_BITS-1:0] SRAD_CRC_INIT = 8'h00;

    // ----------------------------------------------------------------
    // frame sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        SRAD_IDLE = 3'b001,
        SRAD_FRAME = 3'b010,
        SRAD_EXEC = 3'b100
    } srad_state_t;

endpackage

/* srad_crc8.sv */
// bit-serial checksum over the command word, most significant bit first
`timescale 1ns/100ps
`default_nettype none
module srad_crc8
    import srad_pkg::*;
#(
    parameter int WIDTH = SRAD_CRC_BITS
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic clr,
    input wire logic en,
    input wire logic bit_in,
    output logic [WIDTH-1:0] crc_q
);
    logic [WIDTH-1:0] crc_d;

    // shift one bit through the divider
    always_comb begin
        crc_d = crc_q;
        if (clr) begin
            crc_d = SRAD_CRC_INIT;
        end else if (en) begin
            crc_d = {crc_q[WIDTH-2:0], 1'b0} ^ ((crc_q[WIDTH-1] ^ bit_in) ? SRAD_CRC_POLY
                                                                          : SRAD_CRC_INIT);
        end
    end

    // register the remainder
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            crc_q <= SRAD_CRC_INIT;
        end else begin
            crc_q <= crc_d;
        end
    end
endmodule
`default_nettype wire

/* srad_decoder.sv */
// serial command frame decoder and configuration register bank
`timescale 1ns/100ps
`default_nettype none
module srad_decoder
    import srad_pkg::*;
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic serial_input,
    input wire logic [SRAD_FRAME_BITS-1:0] conversion_word,
    input wire logic [SRAD_DATA_BITS-1:0] limit_flags_in,
    output logic primary_serial_output,
    output logic [SRAD_DATA_BITS-1:0] config_primary_q,
    output logic [SRAD_DATA_BITS-1:0] config_secondary_q,
    output logic [SRAD_DATA_BITS-1:0] limit_flags_status_q,
    output logic [SRAD_DATA_BITS-1:0] lower_limit_threshold_q,
    output logic [SRAD_DATA_BITS-1:0] upper_limit_threshold_q
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    srad_state_t state_q, state_d;
    logic sclk_q, sclk_rise, sclk_fall;
    logic [SRAD_CNT_BITS-1:0] cnt_q, cnt_d;
    logic [SRAD_FRAME_BITS-1:0] cmd_q, cmd_d, shout_q, shout_d;
    logic [SRAD_CRC_BITS-1:0] crc_rx_q, crc_rx_d, crc_calc;
    logic sdo_d, pend_q, pend_d;
    logic [SRAD_SEL_BITS-1:0] pend_sel_q, pend_sel_d;
    logic [SRAD_DATA_BITS-1:0] cfg1_d, cfg2_d, low_d, high_d;
    logic crc_clr, crc_en;
    logic wr_flag;
    logic [SRAD_SEL_BITS-1:0] sel;
    logic [SRAD_DATA_BITS-1:0] data;
    logic len_cmd, len_crc, crc_good, crc_need, wr_ok, sel_readable;
    logic [SRAD_FRAME_BITS-1:0] readback;

    // edge detect on the sampled serial clock
    assign sclk_rise = sclk & ~sclk_q;
    assign sclk_fall = ~sclk & sclk_q;

    // command field decode
    assign wr_flag = cmd_q[SRAD_WR_POS];
    assign sel = cmd_q[SRAD_SEL_HI:SRAD_SEL_LO];
    assign data = cmd_q[SRAD_DATA_BITS-1:0];
    assign len_cmd = (cnt_q == SRAD_CNT_CMD);
    assign len_crc = (cnt_q == SRAD_CNT_CRC);
    assign crc_good = len_crc && (crc_rx_q == crc_calc);
    // checksum demanded once enabled, and also to switch it on
    assign crc_need = config_primary_q[SRAD_CRCW_POS]
                      || (sel == SRAD_SEL_CFG1 && data[SRAD_CRCW_POS]);
    assign wr_ok = wr_flag && (crc_need ? crc_good : (len_cmd || crc_good));
    // every mapped register can be read back; none is write-only
    assign sel_readable = (sel >= SRAD_SEL_CFG1) && (sel <= SRAD_SEL_HIGH);

    // readback word for a queued read
    always_comb begin
        case (pend_sel_q)
            SRAD_SEL_CFG1: readback = {1'b0, pend_sel_q, config_primary_q};
            SRAD_SEL_CFG2: readback = {1'b0, pend_sel_q, config_secondary_q};
            SRAD_SEL_STAT: readback = {1'b0, pend_sel_q, limit_flags_status_q};
            SRAD_SEL_LOW: readback = {1'b0, pend_sel_q, lower_limit_threshold_q};
            SRAD_SEL_HIGH: readback = {1'b0, pend_sel_q, upper_limit_threshold_q};
            default: readback = conversion_word;
        endcase
    end

    // ----------------------------------------------------------------
    // next-state logic: framing, shifting, decode and register update
    // ----------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        cmd_d = cmd_q;
        crc_rx_d = crc_rx_q;
        shout_d = shout_q;
        sdo_d = primary_serial_output;
        pend_d = pend_q;
        pend_sel_d = pend_sel_q;
        cfg1_d = config_primary_q;
        cfg2_d = config_secondary_q;
        low_d = lower_limit_threshold_q;
        high_d = upper_limit_threshold_q;
        crc_clr = 1'b0;
        crc_en = 1'b0;
        case (state_q)
            SRAD_IDLE: begin
                if (!cs_n) begin
                    // load the answer: queued register or conversion result
                    shout_d = pend_q ? {readback[SRAD_FRAME_BITS-2:0], 1'b0}
                                     : {conversion_word[SRAD_FRAME_BITS-2:0], 1'b0};
                    sdo_d = pend_q ? readback[SRAD_FRAME_BITS-1]
                                   : conversion_word[SRAD_FRAME_BITS-1];
                    pend_d = 1'b0;
                    cnt_d = SRAD_CNT_ZERO;
                    crc_clr = 1'b1;
                    state_d = SRAD_FRAME;
                end
            end
            SRAD_FRAME: begin
                if (cs_n) begin
                    state_d = SRAD_EXEC;
                end else begin
                    if (sclk_rise) begin
                        if (cnt_q < SRAD_CNT_CMD) begin
                            cmd_d = {cmd_q[SRAD_FRAME_BITS-2:0], serial_input};
                            crc_en = 1'b1;
                        end else if (cnt_q < SRAD_CNT_CRC) begin
                            crc_rx_d = {crc_rx_q[SRAD_CRC_BITS-2:0], serial_input};
                        end
                        if (cnt_q != SRAD_CNT_MAX) begin
                            cnt_d = cnt_q + SRAD_CNT_ONE;
                        end
                    end
                    if (sclk_fall) begin
                        sdo_d = shout_q[SRAD_FRAME_BITS-1];
                        shout_d = {shout_q[SRAD_FRAME_BITS-2:0], 1'b0};
                    end
                end
            end
            SRAD_EXEC: begin
                state_d = SRAD_IDLE;
                if (wr_ok) begin
                    case (sel)
                        SRAD_SEL_CFG1: cfg1_d = data;
                        SRAD_SEL_CFG2: cfg2_d = data;
                        SRAD_SEL_LOW: low_d = data;
                        SRAD_SEL_HIGH: high_d = data;
                        default: ; // status and unlisted codes ignored
                    endcase
                end else if (!wr_flag && (len_cmd || len_crc)) begin
                    pend_d = sel_readable;
                    pend_sel_d = sel;
                end
            end
            default: state_d = SRAD_IDLE;
        endcase
    end

    // register everything; status follows the comparator flags only
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            state_q <= SRAD_IDLE;
            sclk_q <= 1'b0;
            cnt_q <= SRAD_CNT_ZERO;
            cmd_q <= '0;
            crc_rx_q <= SRAD_CRC_INIT;
            shout_q <= '0;
            primary_serial_output <= 1'b0;
            pend_q <= 1'b0;
            pend_sel_q <= '0;
            config_primary_q <= SRAD_RST_CFG1;
            config_secondary_q <= SRAD_RST_CFG2;
            limit_flags_status_q <= SRAD_RST_STAT;
            lower_limit_threshold_q <= SRAD_RST_LOW;
            upper_limit_threshold_q <= SRAD_RST_HIGH;
        end else begin
            state_q <= state_d;
            sclk_q <= sclk;
            cnt_q <= cnt_d;
            cmd_q <= cmd_d;
            crc_rx_q <= crc_rx_d;
            shout_q <= shout_d;
            primary_serial_output <= sdo_d;
            pend_q <= pend_d;
            pend_sel_q <= pend_sel_d;
            config_primary_q <= cfg1_d;
            config_secondary_q <= cfg2_d;
            limit_flags_status_q <= limit_flags_in;
            lower_limit_threshold_q <= low_d;
            upper_limit_threshold_q <= high_d;
        end
    end

    // checksum over the command bits
    srad_crc8 #(.WIDTH(SRAD_CRC_BITS)) u_crc (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .clr(crc_clr),
        .en(crc_en),
        .bit_in(serial_input),
        .crc_q(crc_calc)
    );

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_bit_count: assert property (@(posedge sys_clk) disable iff (!nrst)
        (state_q == SRAD_FRAME && !cs_n && sclk_rise && cnt_q < SRAD_CNT_CMD)
        |=> cnt_q == $past(cnt_q) + SRAD_CNT_ONE)
        else $error("bit counter did not advance");
    a_write_load: assert property (@(posedge sys_clk) disable iff (!nrst)
        (state_q == SRAD_EXEC && len_cmd && wr_flag && sel == SRAD_SEL_CFG2
         && !config_primary_q[SRAD_CRCW_POS])
        |=> config_secondary_q == $past(data))
        else $error("write data not loaded");
    a_read_queue: assert property (@(posedge sys_clk) disable iff (!nrst)
        (state_q == SRAD_EXEC && len_cmd && !wr_flag && sel == SRAD_SEL_LOW)
        |=> pend_q && pend_sel_q == SRAD_SEL_LOW)
        else $error("read not queued");
    a_read_conv: assert property (@(posedge sys_clk) disable iff (!nrst)
        (state_q == SRAD_EXEC && !wr_flag && (sel == 3'h0 || sel > SRAD_SEL_HIGH))
        |=> !pend_q)
        else $error("invalid read queued a register");
    a_ro_write: assert property (@(posedge sys_clk) disable iff (!nrst)
        (state_q == SRAD_EXEC && wr_flag && sel == SRAD_SEL_STAT)
        |=> $stable(config_primary_q) && $stable(config_secondary_q)
            && $stable(lower_limit_threshold_q) && $stable(upper_limit_threshold_q))
        else $error("status write changed a register");
    a_nop_write: assert property (@(posedge sys_clk) disable iff (!nrst)
        (state_q == SRAD_EXEC && wr_flag && (sel == 3'h0 || sel > SRAD_SEL_HIGH))
        |=> $stable(config_primary_q) && $stable(config_secondary_q)
            && $stable(lower_limit_threshold_q) && $stable(upper_limit_threshold_q))
        else $error("unlisted write changed a register");
    a_status_read: assert property (@(posedge sys_clk) disable iff (!nrst)
        (state_q == SRAD_EXEC && len_cmd && !wr_flag && sel == SRAD_SEL_STAT)
        |=> pend_q)
        else $error("status register not readable");
    a_crc_guard: assert property (@(posedge sys_clk) disable iff (!nrst)
        (state_q == SRAD_EXEC && config_primary_q[SRAD_CRCW_POS] && !len_crc)
        |=> $stable(config_primary_q) && $stable(config_secondary_q)
            && $stable(lower_limit_threshold_q) && $stable(upper_limit_threshold_q))
        else $error("unchecked write accepted");
    // queued word goes out top bit first, the rest waits in the shifter in order
    a_msb_first: assert property (@(posedge sys_clk) disable iff (!nrst)
        (state_q == SRAD_IDLE && !cs_n && pend_q)
        |=> {primary_serial_output, shout_q[SRAD_FRAME_BITS-1:1]} == $past(readback))
        else $error("readback msb not first");
endmodule
`default_nettype wire

/* srad_host.sv */
// host side model that sends command frames and collects the returned word
`timescale 1ns/100ps
`default_nettype none
module srad_host (
    input wire logic sys_clk,
    output var logic cs_n,
    output var logic sclk,
    output var logic serial_input,
    input wire logic primary_serial_output
);
    // ----------------------------------------------------------------
    // idle levels: select high, serial clock parked low
    // ----------------------------------------------------------------
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        serial_input = 1'b0;
    end

    // checksum over the command word, most significant bit first
    function automatic logic [7:0] crc_of(input logic [15:0] w);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 15; i >= 0; i--) begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h07 : 8'h00);
        end
        return c;
    endfunction

    task automatic wait_n(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    // one frame of nbits; a bad checksum flips its lowest bit
    task automatic frame(input logic [15:0] cmd, input int nbits, input bit good,
                         output logic [15:0] rx);
        logic [23:0] w;
        w = {cmd, crc_of(cmd) ^ (good ? 8'h00 : 8'h01)};
        rx = 16'h0000;
        @(negedge sys_clk);
        cs_n = 1'b0;
        for (int i = 0; i < nbits; i++) begin
            wait_n(2);
            serial_input = w[23-i];
            wait_n(2);
            if (i < 16) begin
                rx[15-i] = primary_serial_output;
            end
            sclk = 1'b1;
            wait_n(2);
            sclk = 1'b0;
        end
        wait_n(2);
        cs_n = 1'b1;
        serial_input = ~serial_input; // released line shows no stale value
        wait_n(3);
    endtask
endmodule
`default_nettype wire

/* tb_top.sv */
// self-checking testbench for the serial register access decoder
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import srad_pkg::*;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic cs_n;
    logic sclk;
    logic serial_input;
    logic primary_serial_output;
    logic [15:0] conversion_word = 16'hC35A;
    logic [11:0] limit_flags_in = 12'h0A5;
    logic [11:0] cfg1, cfg2, stat, low, high;
    logic [11:0] exp_r [1:5];
    logic [15:0] rx;
    int n_mismatch = 0;
    int num_checks = 0;

    always #5 sys_clk = ~sys_clk;

    srad_decoder dut (.sys_clk(sys_clk), .nrst(nrst), .sclk(sclk), .cs_n(cs_n),
        .serial_input(serial_input), .conversion_word(conversion_word),
        .limit_flags_in(limit_flags_in), .primary_serial_output(primary_serial_output),
        .config_primary_q(cfg1), .config_secondary_q(cfg2), .limit_flags_status_q(stat),
        .lower_limit_threshold_q(low), .upper_limit_threshold_q(high));

    srad_host u_host (.sys_clk(sys_clk), .cs_n(cs_n), .sclk(sclk),
        .serial_input(serial_input), .primary_serial_output(primary_serial_output));

    // ----------------------------------------------------------------
    // compare helpers and closing report
    // ----------------------------------------------------------------
    task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic chk_regs();
        logic [11:0] seen [1:5];
        seen = '{cfg1, cfg2, stat, low, high};
        exp_r[3] = limit_flags_in;
        for (int s = 1; s <= 5; s++) begin
            chk($sformatf("register %0d", s), {4'h0, exp_r[s]}, {4'h0, seen[s]});
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // bound on the whole run
    initial begin
        repeat (60000) @(posedge sys_clk);
        n_mismatch++;
        test_done();
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (12) @(negedge sys_clk);
        nrst = 1'b1;
        exp_r = '{12'h000, 12'h000, 12'h000, 12'h800, 12'h7FF};
        @(negedge sys_clk);
        chk_regs();
        // write every select code; only 1, 2, 4 and 5 take the data
        for (int s = 0; s < 8; s++) begin
            u_host.frame({1'b1, 3'(s), 3'(s), 9'h15A}, 16, 1'b1, rx);
            if (s inside {1, 2, 4, 5}) begin
                exp_r[s] = {3'(s), 9'h15A};
            end
            chk_regs();
        end
        // read every select code, answer comes in the following frame
        limit_flags_in = 12'h3C6;
        for (int s = 0; s < 8; s++) begin
            u_host.frame({1'b0, 3'(s), 12'hFFF}, 16, 1'b1, rx);
            chk("conversion after nop", conversion_word, rx);
            u_host.frame({1'b0, 3'h0, 12'h000}, 16, 1'b1, rx);
            exp_r[3] = limit_flags_in;
            if (s inside {[1:5]}) begin
                chk("readback", {1'b0, 3'(s), exp_r[s]}, rx);
            end else begin
                chk("conversion", conversion_word, rx);
            end
        end
        // a frame one clock short is discarded
        u_host.frame({1'b1, 3'h2, 12'hABC}, 15, 1'b1, rx);
        chk_regs();
        // turning checksum writes on needs a valid checksum
        u_host.frame({1'b1, 3'h1, 12'h020}, 16, 1'b1, rx);
        chk_regs();
        u_host.frame({1'b1, 3'h1, 12'h020}, 24, 1'b0, rx);
        chk_regs();
        u_host.frame({1'b1, 3'h1, 12'h020}, 24, 1'b1, rx);
        exp_r[1] = 12'h020;
        chk_regs();
        u_host.frame({1'b1, 3'h2, 12'h777}, 16, 1'b1, rx);
        chk_regs();
        u_host.frame({1'b1, 3'h2, 12'h777}, 24, 1'b1, rx);
        exp_r[2] = 12'h777;
        chk_regs();
        u_host.frame({1'b1, 3'h1, 12'h000}, 24, 1'b1, rx);
        exp_r[1] = 12'h000;
        u_host.frame({1'b1, 3'h4, 12'h123}, 16, 1'b1, rx);
        exp_r[4] = 12'h123;
        chk_regs();
        // second reset in mid-run restores the reset values and drops a queued read
        u_host.frame({1'b0, 3'h4, 12'h000}, 16, 1'b1, rx);
        chk("conversion before reset", conversion_word, rx);
        nrst = 1'b0;
        repeat (2) @(negedge sys_clk);
        nrst = 1'b1;
        exp_r = '{12'h000, 12'h000, 12'h000, 12'h800, 12'h7FF};
        @(negedge sys_clk);
        chk_regs();
        u_host.frame({1'b0, 3'h0, 12'h000}, 16, 1'b1, rx);
        chk("conversion after reset", conversion_word, rx);
        test_done();
    end
endmodule
`default_nettype wire
